// ===== design/backlight_cfg_pkg.sv
// backlight_cfg_pkg: offsets, field positions, reset values and carriers
// for the lockout/dimming and resolution/current/fault/headroom registers.
// assumes a 32-bit ahb-lite bus with word-aligned registers.
`default_nettype none

package backlight_cfg_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] lockout_and_dimming_mode_config_off          = 8'ha3;
  localparam logic [7:0] resolution_current_fault_headroom_config_off = 8'ha4;
  localparam logic [9:0] lockout_and_dimming_mode_config_addr          = {lockout_and_dimming_mode_config_off, 2'b00};
  localparam logic [9:0] resolution_current_fault_headroom_config_addr =
    {resolution_current_fault_headroom_config_off, 2'b00};
  localparam logic [7:0] cfg3_reset = 8'h00;
  localparam logic [7:0] cfg4_reset = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int lockout_lsb     = 6;
  localparam int phase_shift_bit = 5;
  localparam int rate_lsb        = 0;
  localparam int resolution_lsb  = 6;
  localparam int set_res_bit     = 5;
  localparam int fault_thr_lsb   = 3;
  localparam int headroom_lsb    = 0;

  // ----------------------------------------
  // decoded values in millivolts, plus the base resolution in bits
  // ----------------------------------------
  localparam logic [13:0] lockout_mv_1  = 14'd2700;
  localparam logic [13:0] lockout_mv_2  = 14'd6000;
  localparam logic [13:0] lockout_mv_3  = 14'd9000;
  localparam logic [13:0] fault_mv_base = 14'd2300;
  localparam logic [13:0] fault_mv_step = 14'd1000;
  localparam logic [13:0] headroom_step = 14'd125;
  localparam logic [3:0]  resolution_base_bits = 4'd8;

  typedef struct packed {
    logic [1:0] input_lockout_level;
    logic       phase_shift_dimming_enable;
    logic [4:0] dimming_rate_select;
  } cfg3_t;

  typedef struct packed {
    logic [1:0] resolution_range;
    logic       current_set_resistor;
    logic [1:0] string_fault_threshold;
    logic [2:0] sink_headroom_target;
  } cfg4_t;

  typedef struct packed {
    logic        lockout_enable;
    logic [13:0] lockout_mv;
    logic        phase_shift_dimming_enable;
    logic [4:0]  dimming_rate_select;
    logic [3:0]  min_resolution_bits;
    logic [3:0]  max_resolution_bits;
    logic        current_set_resistor;
    logic [13:0] fault_threshold_mv;
    logic [13:0] headroom_above_sat_mv;
    logic        adaptive_regulate;
  } ctrl_t;

endpackage : backlight_cfg_pkg

`default_nettype wire

// ===== design/backlight_config_regs_3_4.sv
// backlight_config_regs_3_4: ahb-lite slave holding two 8-bit configuration
// registers and decoding them into control levels for the analog stages.
// assumes a single master, word transfers only; analog blocks consume ctrl.
`timescale 1ns/1ps
`default_nettype none

module backlight_config_regs_3_4 (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  input  wire logic                     adaptive_enable,
  output logic [31:0]                   hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  output backlight_cfg_pkg::ctrl_t      ctrl
);
  import backlight_cfg_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    cfg3_t       cfg3;
    cfg4_t       cfg4;
    logic        wr_pend;
    logic [9:0]  wr_addr;
    logic [31:0] rdata;
    logic        hreadyout;
    logic        hresp;
    logic        adapt_sync1;
    logic        adapt_sync2;
    logic        adapt_sync3;
    ctrl_t       ctrl;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ready stays high through reset so the bus never sees a stall
  localparam state_t state_reset = '{cfg3: cfg3_t'(cfg3_reset), cfg4: cfg4_t'(cfg4_reset), hreadyout: 1'b1,
                                     default: '0};
  localparam logic [9:0] cfg3_word = {2'b00, lockout_and_dimming_mode_config_off};
  localparam logic [9:0] cfg4_word = {2'b00, resolution_current_fault_headroom_config_off};

  logic       access;
  logic [9:0] word_addr;

  assign access    = hsel && hready && htrans[1];
  assign word_addr = haddr[11:2];

  always_comb begin
    next_cur = cur;
    // ----------------------------------------
    // bus: write lands in data phase, read data registered from address phase
    // ----------------------------------------
    if (cur.wr_pend) begin
      if (cur.wr_addr == cfg3_word) begin
        next_cur.cfg3 = cfg3_t'(hwdata[7:0]);
      end else if (cur.wr_addr == cfg4_word) begin
        next_cur.cfg4 = cfg4_t'(hwdata[7:0]);
      end
    end
    next_cur.wr_pend = access && hwrite;
    next_cur.wr_addr = word_addr;
    // zero wait states, always okay
    next_cur.hreadyout = 1'b1;
    next_cur.hresp     = 1'b0;
    if (access && !hwrite) begin
      // unmapped words read zero; upper bits always zero
      if (word_addr == cfg3_word) begin
        next_cur.rdata = {24'h000000, cur.cfg3};
      end else if (word_addr == cfg4_word) begin
        next_cur.rdata = {24'h000000, cur.cfg4};
      end else begin
        next_cur.rdata = 32'h00000000;
      end
    end
    // pin synchroniser: change counts once stages two and three agree
    next_cur.adapt_sync1 = adaptive_enable;
    next_cur.adapt_sync2 = cur.adapt_sync1;
    next_cur.adapt_sync3 = cur.adapt_sync2;
    if (cur.adapt_sync2 == cur.adapt_sync3) begin
      next_cur.ctrl.adaptive_regulate = cur.adapt_sync3;
    end
    // ----------------------------------------
    // decode to control levels
    // ----------------------------------------
    next_cur.ctrl.lockout_enable = (cur.cfg3.input_lockout_level != 2'b00);
    case (cur.cfg3.input_lockout_level)
      2'b01:   next_cur.ctrl.lockout_mv = lockout_mv_1;
      2'b10:   next_cur.ctrl.lockout_mv = lockout_mv_2;
      2'b11:   next_cur.ctrl.lockout_mv = lockout_mv_3;
      default: next_cur.ctrl.lockout_mv = 14'd0;
    endcase
    next_cur.ctrl.phase_shift_dimming_enable = cur.cfg3.phase_shift_dimming_enable;
    next_cur.ctrl.dimming_rate_select        = cur.cfg3.dimming_rate_select;
    // min at 19.2 kHz, max (two more bits) at 4.8 kHz
    next_cur.ctrl.min_resolution_bits = resolution_base_bits + {2'b00, cur.cfg4.resolution_range};
    next_cur.ctrl.max_resolution_bits = resolution_base_bits + {2'b00, cur.cfg4.resolution_range} + 4'd2;
    next_cur.ctrl.current_set_resistor = cur.cfg4.current_set_resistor;
    next_cur.ctrl.fault_threshold_mv = fault_mv_base
      + 14'(fault_mv_step * {12'd0, cur.cfg4.string_fault_threshold});
    // target measured above sink_saturation_voltage; analog side adds it
    next_cur.ctrl.headroom_above_sat_mv = 14'(headroom_step * ({11'd0, cur.cfg4.sink_headroom_target} + 14'd1));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= state_reset;
    end else begin
      cur <= next_cur;
    end
  end

  assign hrdata    = cur.rdata;
  assign hreadyout = cur.hreadyout;
  assign hresp     = cur.hresp;
  assign ctrl      = cur.ctrl;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_lockout_decode;
    @(posedge hclk) disable iff (!hresetn)
      (cur.cfg3.input_lockout_level == 2'b11) |=> (ctrl.lockout_mv == lockout_mv_3 && ctrl.lockout_enable);
  endproperty
  a_lockout_decode: assert property (p_lockout_decode) else $error("lockout 9V not decoded");

  property p_lockout_off;
    @(posedge hclk) disable iff (!hresetn)
      (cur.cfg3.input_lockout_level == 2'b00) |=> !ctrl.lockout_enable;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("lockout not off");

  property p_phase_shift;
    @(posedge hclk) disable iff (!hresetn)
      (cur.wr_pend && cur.wr_addr == cfg3_word)
      |=> ##1 (ctrl.phase_shift_dimming_enable == $past(hwdata[phase_shift_bit], 2));
  endproperty
  a_phase_shift: assert property (p_phase_shift) else $error("phase shift mode wrong");

  property p_rate;
    @(posedge hclk) disable iff (!hresetn)
      (cur.wr_pend && cur.wr_addr == cfg3_word)
      |=> ##1 (ctrl.dimming_rate_select == $past(hwdata[4:0], 2));
  endproperty
  a_rate: assert property (p_rate) else $error("rate select wrong");

  property p_resolution;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (ctrl.min_resolution_bits == 4'd8 + {2'b00, $past(cur.cfg4.resolution_range)}
                && ctrl.max_resolution_bits == 4'd10 + {2'b00, $past(cur.cfg4.resolution_range)});
  endproperty
  a_resolution: assert property (p_resolution) else $error("resolution span wrong");

  property p_resistor;
    @(posedge hclk) disable iff (!hresetn)
      $stable(cur.cfg4.current_set_resistor) |=> (ctrl.current_set_resistor == $past(cur.cfg4.current_set_resistor));
  endproperty
  a_resistor: assert property (p_resistor) else $error("set resistor mode wrong");

  property p_fault_max;
    @(posedge hclk) disable iff (!hresetn)
      (cur.cfg4.string_fault_threshold == 2'b11) |=> (ctrl.fault_threshold_mv == 14'd5300);
  endproperty
  a_fault_max: assert property (p_fault_max) else $error("fault threshold wrong");

  property p_headroom;
    @(posedge hclk) disable iff (!hresetn)
      (cur.cfg4.sink_headroom_target == 3'b111) |=> (ctrl.headroom_above_sat_mv == 14'd1000);
  endproperty
  a_headroom: assert property (p_headroom) else $error("headroom target wrong");

  property p_adapt;
    @(posedge hclk) disable iff (!hresetn)
      (adaptive_enable [*5]) |=> ctrl.adaptive_regulate;
  endproperty
  a_adapt: assert property (p_adapt) else $error("adaptive enable not followed");

  property p_adapt_off;
    @(posedge hclk) disable iff (!hresetn)
      ((!adaptive_enable) [*5]) |=> !ctrl.adaptive_regulate;
  endproperty
  a_adapt_off: assert property (p_adapt_off) else $error("adaptive disable not followed");

  property p_lockout_low;
    @(posedge hclk) disable iff (!hresetn)
      (cur.cfg3.input_lockout_level == 2'b01) |=> (ctrl.lockout_mv == 14'd2700 && ctrl.lockout_enable);
  endproperty
  a_lockout_low: assert property (p_lockout_low) else $error("lockout 2.7V not decoded");

  property p_lockout_mid;
    @(posedge hclk) disable iff (!hresetn)
      (cur.cfg3.input_lockout_level == 2'b10) |=> (ctrl.lockout_mv == 14'd6000 && ctrl.lockout_enable);
  endproperty
  a_lockout_mid: assert property (p_lockout_mid) else $error("lockout 6V not decoded");

  property p_phase_follow;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (ctrl.phase_shift_dimming_enable == $past(cur.cfg3.phase_shift_dimming_enable));
  endproperty
  a_phase_follow: assert property (p_phase_follow) else $error("phase shift mode not held");

  property p_rate_follow;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (ctrl.dimming_rate_select == $past(cur.cfg3.dimming_rate_select));
  endproperty
  a_rate_follow: assert property (p_rate_follow) else $error("rate select not held");

  property p_fault_min;
    @(posedge hclk) disable iff (!hresetn)
      (cur.cfg4.string_fault_threshold == 2'b00) |=> (ctrl.fault_threshold_mv == 14'd2300);
  endproperty
  a_fault_min: assert property (p_fault_min) else $error("lowest fault threshold wrong");

  property p_fault_step;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (ctrl.fault_threshold_mv == 14'd2300 + 14'd1000 * {12'd0, $past(cur.cfg4.string_fault_threshold)});
  endproperty
  a_fault_step: assert property (p_fault_step) else $error("fault threshold step wrong");

  property p_headroom_min;
    @(posedge hclk) disable iff (!hresetn)
      (cur.cfg4.sink_headroom_target == 3'b000) |=> (ctrl.headroom_above_sat_mv == 14'd125);
  endproperty
  a_headroom_min: assert property (p_headroom_min) else $error("lowest headroom target wrong");

  property p_headroom_step;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |=> (ctrl.headroom_above_sat_mv == 14'd125 * ({11'd0, $past(cur.cfg4.sink_headroom_target)} + 14'd1));
  endproperty
  a_headroom_step: assert property (p_headroom_step) else $error("headroom step wrong");

  // ----------------------------------------
  // bus checks
  // ----------------------------------------
  property p_zero_wait;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |-> (hreadyout && !hresp);
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("slave stalled or erred");

  property p_read_upper_zero;
    @(posedge hclk) disable iff (!hresetn)
      1'b1 |-> (hrdata[31:8] == 24'h000000);
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits not zero");

  property p_read_cfg3;
    @(posedge hclk) disable iff (!hresetn)
      (access && !hwrite && word_addr == cfg3_word) |=> (hrdata[7:0] == $past(cur.cfg3));
  endproperty
  a_read_cfg3: assert property (p_read_cfg3) else $error("first register read back wrong");

  property p_read_cfg4;
    @(posedge hclk) disable iff (!hresetn)
      (access && !hwrite && word_addr == cfg4_word) |=> (hrdata[7:0] == $past(cur.cfg4));
  endproperty
  a_read_cfg4: assert property (p_read_cfg4) else $error("second register read back wrong");

  property p_read_unmapped;
    @(posedge hclk) disable iff (!hresetn)
      (access && !hwrite && word_addr != cfg3_word && word_addr != cfg4_word) |=> (hrdata == 32'h00000000);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped read not zero");

  property p_write_cfg3;
    @(posedge hclk) disable iff (!hresetn)
      (cur.wr_pend && cur.wr_addr == cfg3_word) |=> (cur.cfg3 == $past(hwdata[7:0]));
  endproperty
  a_write_cfg3: assert property (p_write_cfg3) else $error("first register write lost");

  property p_write_cfg4;
    @(posedge hclk) disable iff (!hresetn)
      (cur.wr_pend && cur.wr_addr == cfg4_word) |=> (cur.cfg4 == $past(hwdata[7:0]));
  endproperty
  a_write_cfg4: assert property (p_write_cfg4) else $error("second register write lost");

  property p_write_unmapped;
    @(posedge hclk) disable iff (!hresetn)
      (cur.wr_pend && cur.wr_addr != cfg3_word && cur.wr_addr != cfg4_word) |=> ($stable(cur.cfg3) && $stable(cur.cfg4));
  endproperty
  a_write_unmapped: assert property (p_write_unmapped) else $error("unmapped write changed a register");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_write3: cover property (@(posedge hclk) disable iff (!hresetn)
    cur.wr_pend && cur.wr_addr == cfg3_word);
  c_write4: cover property (@(posedge hclk) disable iff (!hresetn)
    cur.wr_pend && cur.wr_addr == cfg4_word);
  c_read: cover property (@(posedge hclk) disable iff (!hresetn) access && !hwrite);
  c_phase_shift: cover property (@(posedge hclk) disable iff (!hresetn)
    ctrl.phase_shift_dimming_enable);
  c_adapt: cover property (@(posedge hclk) disable iff (!hresetn)
    ctrl.adaptive_regulate);

endmodule : backlight_config_regs_3_4

`default_nettype wire

// ===== tb/ahb_host_model.sv
// ahb_host_model: single ahb-lite master issuing whole-word single transfers.
// assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/1ps
`default_nettype none

module ahb_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // ----------------------------------------
  // one transfer: address phase, then data phase
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    haddr  <= ~a;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // released data shows its inverse, so a late sample is caught
    hwdata <= ~d;
  endtask : xfer
endmodule : ahb_host_model

`default_nettype wire

// ===== tb/tb_backlight_config_regs_3_4.sv
// tb_backlight_config_regs_3_4: self-checking bench for the two config registers.
// assumes the host model as the only bus master; hready fed from hreadyout.
`timescale 1ns/1ps
`default_nettype none

module tb_backlight_config_regs_3_4;
  import backlight_cfg_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        adaptive_enable;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  ctrl_t       ctrl;
  logic [31:0] rd;
  logic [7:0]  c3;
  logic [7:0]  c4;
  int          failures;
  int          cmp_count;
  int          cycles = 0;

  backlight_config_regs_3_4 backlight_config_regs_3_4_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .adaptive_enable(adaptive_enable), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ctrl(ctrl));
  ahb_host_model ahb_host_model_inst (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge hclk) begin
    cycles++;
    if (cycles >= 3000) begin
      failures++;
      tally_and_finish();
    end
  end

  function automatic ctrl_t exp_ctrl(input logic [7:0] a, input logic [7:0] b, input logic ad);
    ctrl_t e;
    e.lockout_enable             = (a[7:6] != 2'b00);
    e.lockout_mv                 = (a[7:6] == 2'b01) ? 14'd2700 : (a[7:6] == 2'b10) ? 14'd6000 :
                                   (a[7:6] == 2'b11) ? 14'd9000 : 14'd0;
    e.phase_shift_dimming_enable = a[5];
    e.dimming_rate_select        = a[4:0];
    e.min_resolution_bits        = 4'd8 + {2'b00, b[7:6]};
    e.max_resolution_bits        = 4'd10 + {2'b00, b[7:6]};
    e.current_set_resistor       = b[5];
    e.fault_threshold_mv         = 14'd2300 + 14'd1000 * {12'h0, b[4:3]};
    e.headroom_above_sat_mv      = 14'd125 * ({11'h0, b[2:0]} + 14'd1);
    e.adaptive_regulate          = ad;
    return e;
  endfunction : exp_ctrl

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    // upper data bits set high: they must be dropped
    ahb_host_model_inst.xfer(1'b1, {22'h0, a}, {24'hffffff, v}, rd);
  endtask : wr

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] v);
    ahb_host_model_inst.xfer(1'b0, {22'h0, a}, 32'h0, rd);
    check(64'(rd), {56'h0, v});
    check(64'(hresp), 64'h0);
  endtask : rd_chk

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    failures        = 0;
    cmp_count       = 0;
    hresetn         = 1'b0;
    adaptive_enable = 1'b0;
    repeat (12) @(posedge hclk);
    check(64'(ctrl), 64'h0);
    check({62'h0, hreadyout, hresp}, 64'h2);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check(64'(ctrl), 64'(exp_ctrl(8'h00, 8'h00, 1'b0)));
    rd_chk(lockout_and_dimming_mode_config_addr, 8'h00);
    rd_chk(resolution_current_fault_headroom_config_addr, 8'h00);
    for (int i = 0; i < 8; i++) begin
      c3 = {i[1:0], i[2], 5'(i * 9 + 1)};
      c4 = {~i[1:0], i[0], i[2:1], i[2:0]};
      wr(lockout_and_dimming_mode_config_addr, c3);
      wr(resolution_current_fault_headroom_config_addr, c4);
      repeat (2) @(posedge hclk);
      check(64'(ctrl), 64'(exp_ctrl(c3, c4, 1'b0)));
      rd_chk(lockout_and_dimming_mode_config_addr, c3);
      rd_chk(resolution_current_fault_headroom_config_addr, c4);
    end
    // unmapped word next to the bank: write dropped, reads zero
    wr(10'h294, 8'h5a);
    rd_chk(10'h294, 8'h00);
    rd_chk(lockout_and_dimming_mode_config_addr, c3);
    adaptive_enable <= 1'b1;
    repeat (8) @(posedge hclk);
    check(64'(ctrl), 64'(exp_ctrl(c3, c4, 1'b1)));
    adaptive_enable <= 1'b0;
    repeat (8) @(posedge hclk);
    check(64'(ctrl), 64'(exp_ctrl(c3, c4, 1'b0)));
    // second reset in mid-run clears both registers
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check(64'(ctrl), 64'h0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd_chk(resolution_current_fault_headroom_config_addr, 8'h00);
    tally_and_finish();
  end
endmodule : tb_backlight_config_regs_3_4

`default_nettype wire
